// *** rtl/ecct_cfg.svh ***
// register offsets, field positions, reset values and divider counts of the 8-bit timer
`ifndef ECCT_CFG_SVH
`define ECCT_CFG_SVH

`define ECCT_OFS_CTRL_B 8'h51
`define ECCT_OFS_CTRL_A 8'h52
`define ECCT_OFS_STATUS 8'h53
`define ECCT_OFS_CAP1_HI 8'h54
`define ECCT_OFS_CAP1_LO 8'h55
`define ECCT_OFS_CMP1_HI 8'h56
`define ECCT_OFS_CMP1_LO 8'h57
`define ECCT_OFS_CNT_HI 8'h58
`define ECCT_OFS_CNT_LO 8'h59
`define ECCT_OFS_ACNT_HI 8'h5a
`define ECCT_OFS_ACNT_LO 8'h5b
`define ECCT_OFS_CAP2_HI 8'h5c
`define ECCT_OFS_CAP2_LO 8'h5d
`define ECCT_OFS_CMP2_HI 8'h5e
`define ECCT_OFS_CMP2_LO 8'h5f

`define ECCT_A_CAPTURE_IRQ_ENABLE 7
`define ECCT_A_COMPARE_IRQ_ENABLE 6
`define ECCT_A_OVERFLOW_IRQ_ENABLE 5
`define ECCT_A_OLVL2 2
`define ECCT_A_CAPTURE_ONE_EDGE_SELECT 1
`define ECCT_A_OLVL1 0
`define ECCT_B_COMPARE_ONE_PIN_ENABLE 7
`define ECCT_B_COMPARE_TWO_PIN_ENABLE 6
`define ECCT_B_OPM 5
`define ECCT_B_PWM 4
`define ECCT_B_CC_HI 3
`define ECCT_B_CC_LO 2
`define ECCT_B_CAPTURE_TWO_EDGE_SELECT 1
`define ECCT_S_CAPTURE_ONE_FLAG 7
`define ECCT_S_COMPARE_ONE_FLAG 6
`define ECCT_S_TOF 5
`define ECCT_S_CAPTURE_TWO_FLAG 4
`define ECCT_S_COMPARE_TWO_FLAG 3
`define ECCT_S_TIMD 2

`define ECCT_FL_OVF 0
`define ECCT_FL_CAP1 1
`define ECCT_FL_CAP2 2
`define ECCT_FL_CMP1 3
`define ECCT_FL_CMP2 4

`define ECCT_CNT_RELOAD 8'hfc
`define ECCT_CNT_MAX 8'hff
`define ECCT_CTRL_RST 8'h00
`define ECCT_CMP_RST 8'h00
`define ECCT_HIGH_READ 8'hff

`define ECCT_DIV2_LAST 13'h0001
`define ECCT_DIV4_LAST 13'h0003
`define ECCT_DIV8_LAST 13'h0007
`define ECCT_SLOW_DIV 8000

`endif

// *** rtl/ecct_pkg.sv ***
// types shared by the 8-bit capture/compare timer
package ecct_pkg;
   typedef logic [7:0] ecct_byte_t;
   typedef logic [31:0] ecct_word_t;
   // declaration order gives the clock select field encoding 00..11
   typedef enum logic [1:0] {ECCT_DIV4, ECCT_DIV2, ECCT_DIV8, ECCT_SLOW} ecct_clk_sel_t;
endpackage

// *** rtl/ecct_timer.sv ***
// 8-bit free-running timer with two captures, two compares and an avalon-mm slave
// Overview of operation
// R1 - eight-bit up-counter advances once per tick
// R2 - counter register writes reload the count FCh
// R3 - FCh is the only reload and reset value
// R4 - tick from cpu clock or slow oscillator
// R5 - select 00 /4, 01 /2, 10 /8, 11 slow
// R6 - wrap from FFh to 00h sets overflow flag
// R7 - overflow irq needs enable and clear cpu mask
// R8 - status read then counter access clears overflow
// R9 - alternate counter reads never clear overflow
// R10 - wait mode leaves the counter running
// R11 - halt freezes count, reset restarts it
// R12 - capture edge copies counter into capture register
// R13 - per-channel edge select bit
// R14 - select one rising, zero falling
// R15 - capture sets flag, gated shared irq
// R16 - one capture enable serves both channels
// R17 - status read then capture access clears flag
// R18 - capture register keeps the latest capture
// R19 - pulse modes leave only channel two capturing
// R20 - any pin transition on the selected edge triggers a capture
// R21 - unbonded capture input reads as one
// R22 - compare match sets flag, drives pin, irq
// R23 - compare registers zero at reset, software only
// R24 - capture pins synchronised before edge detection
// R25 - clears and reloads land on next tick
`include "ecct_cfg.svh"

module ecct_timer #(
   parameter int unsigned SLOW_DIV = `ECCT_SLOW_DIV,
   parameter logic [1:0] CAP_BONDED = 2'b11
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire ecct_pkg::ecct_word_t avs_writedata,
   output ecct_pkg::ecct_word_t avs_readdata,
   output logic avs_waitrequest,
   input wire logic capture_one_input,
   input wire logic capture_two_input,
   input wire logic secondary_oscillator_clock,
   input wire logic cpu_irq_mask,
   input wire logic halt_mode,
   output logic compare_one_output,
   output logic compare_one_output_en,
   output logic compare_two_output,
   output logic compare_two_output_en,
   output logic timer_irq
);
   import ecct_pkg::*;

   ecct_byte_t ctrl_a_q, ctrl_b_q, cnt_q;
   ecct_byte_t cmp_lo_q [2];
   ecct_byte_t cmp_hi_q [2];
   ecct_byte_t cap_q [2];
   ecct_byte_t rd_mux;
   ecct_word_t rdata_q;
   logic wait_q, timd_q, reload_pend_q, irq_q;
   logic [4:0] flag_q, arm_q, pend_q, set_evt, clr_acc;
   logic [1:0] cap_evt, edge_sel, pin_in, pen, lvl, out_q, oe_q;
   logic [1:0] cs1_q, cs2_q, cs3_q;
   logic os1_q, os2_q, os3_q, osc_rise;
   logic [12:0] pre_q, pre_last;
   logic acc, wr_en, rd_en, stat_rd, run, tick, pulse_mode;
   ecct_clk_sel_t clk_sel;

   localparam logic [12:0] SLOW_LAST = 13'(SLOW_DIV - 1);

   // ---------------- avalon-mm slave ----------------
   // one wait cycle: read data is prepared while waitrequest is high, and every side
   // effect happens on the single edge where the master sees waitrequest low
   assign acc = (avs_read | avs_write) & ~wait_q;
   assign wr_en = avs_write & acc & avs_byteenable[0];
   assign rd_en = avs_read & acc;
   assign stat_rd = rd_en && avs_address == `ECCT_OFS_STATUS;

   always_comb begin
      case (avs_address)
         `ECCT_OFS_CTRL_B: rd_mux = ctrl_b_q;
         `ECCT_OFS_CTRL_A: rd_mux = ctrl_a_q;
         `ECCT_OFS_STATUS: rd_mux = {flag_q[`ECCT_FL_CAP1], flag_q[`ECCT_FL_CMP1],
                                     flag_q[`ECCT_FL_OVF], flag_q[`ECCT_FL_CAP2],
                                     flag_q[`ECCT_FL_CMP2], timd_q, 2'b00};
         `ECCT_OFS_CAP1_LO: rd_mux = cap_q[0];
         `ECCT_OFS_CAP2_LO: rd_mux = cap_q[1];
         `ECCT_OFS_CMP1_LO: rd_mux = cmp_lo_q[0];
         `ECCT_OFS_CMP2_LO: rd_mux = cmp_lo_q[1];
         `ECCT_OFS_CMP1_HI: rd_mux = cmp_hi_q[0];
         `ECCT_OFS_CMP2_HI: rd_mux = cmp_hi_q[1];
         `ECCT_OFS_CNT_LO, `ECCT_OFS_ACNT_LO: rd_mux = cnt_q; // R9
         `ECCT_OFS_CAP1_HI, `ECCT_OFS_CAP2_HI,
         `ECCT_OFS_CNT_HI, `ECCT_OFS_ACNT_HI: rd_mux = `ECCT_HIGH_READ;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if ((avs_read | avs_write) & wait_q) begin
         wait_q <= 1'b0;
         rdata_q <= {24'h00_0000, rd_mux};
      end else begin
         wait_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_a_q <= `ECCT_CTRL_RST;
         ctrl_b_q <= `ECCT_CTRL_RST;
         timd_q <= 1'b0;
         for (int c = 0; c < 2; c++) begin
            cmp_lo_q[c] <= `ECCT_CMP_RST; // R23
            cmp_hi_q[c] <= `ECCT_CMP_RST;
         end
      end else if (wr_en) begin
         case (avs_address)
            `ECCT_OFS_CTRL_A: ctrl_a_q <= avs_writedata[7:0];
            `ECCT_OFS_CTRL_B: ctrl_b_q <= avs_writedata[7:0];
            `ECCT_OFS_STATUS: timd_q <= avs_writedata[`ECCT_S_TIMD];
            `ECCT_OFS_CMP1_LO: cmp_lo_q[0] <= avs_writedata[7:0]; // R23
            `ECCT_OFS_CMP2_LO: cmp_lo_q[1] <= avs_writedata[7:0]; // R23
            `ECCT_OFS_CMP1_HI: cmp_hi_q[0] <= avs_writedata[7:0];
            `ECCT_OFS_CMP2_HI: cmp_hi_q[1] <= avs_writedata[7:0];
            default: ;
         endcase
      end
   end

   // ---------------- prescaler ----------------
   assign clk_sel = ecct_clk_sel_t'(ctrl_b_q[`ECCT_B_CC_HI:`ECCT_B_CC_LO]);
   // no wait-mode input at all: the timer cannot be stopped by it
   assign run = ~halt_mode & ~timd_q; // R10 R11
   assign osc_rise = os2_q & ~os3_q;

   always_comb begin
      case (clk_sel) // R5
         ECCT_DIV2: pre_last = `ECCT_DIV2_LAST;
         ECCT_DIV4: pre_last = `ECCT_DIV4_LAST;
         ECCT_DIV8: pre_last = `ECCT_DIV8_LAST;
         ECCT_SLOW: pre_last = SLOW_LAST;
         default: pre_last = `ECCT_DIV4_LAST;
      endcase
   end

   // >= rather than == so a select change mid-count cannot strand the prescaler
   assign tick = run && pre_q >= pre_last && (clk_sel != ECCT_SLOW || osc_rise); // R4

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         os1_q <= 1'b0;
         os2_q <= 1'b0;
         os3_q <= 1'b0;
      end else begin
         os1_q <= secondary_oscillator_clock;
         os2_q <= os1_q;
         os3_q <= os2_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pre_q <= 13'h0000;
      end else if (run && (clk_sel != ECCT_SLOW || osc_rise)) begin
         pre_q <= tick ? 13'h0000 : pre_q + 13'h0001; // R4
      end
   end

   // ---------------- counter ----------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_q <= `ECCT_CNT_RELOAD; // R3 R11
      end else if (tick) begin
         if (reload_pend_q) cnt_q <= `ECCT_CNT_RELOAD; // R2 R3 R25
         else cnt_q <= cnt_q + 8'h01; // R1
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reload_pend_q <= 1'b0;
      end else if (wr_en && (avs_address == `ECCT_OFS_CNT_LO ||
                             avs_address == `ECCT_OFS_ACNT_LO)) begin
         reload_pend_q <= 1'b1; // R2
      end else if (tick) begin
         reload_pend_q <= 1'b0; // R25
      end
   end

   // ---------------- input capture ----------------
   assign pulse_mode = ctrl_b_q[`ECCT_B_OPM] | ctrl_b_q[`ECCT_B_PWM];
   assign edge_sel = {ctrl_b_q[`ECCT_B_CAPTURE_TWO_EDGE_SELECT], ctrl_a_q[`ECCT_A_CAPTURE_ONE_EDGE_SELECT]}; // R13
   assign pin_in = {capture_two_input, capture_one_input};

   genvar c;
   for (c = 0; c < 2; c++) begin : g_cap
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            cs1_q[c] <= 1'b1;
            cs2_q[c] <= 1'b1;
            cs3_q[c] <= 1'b1;
         end else begin
            cs1_q[c] <= CAP_BONDED[c] ? pin_in[c] : 1'b1; // R21 R24
            cs2_q[c] <= cs1_q[c];
            cs3_q[c] <= cs2_q[c];
         end
      end
      // pins stay wired in whatever direction the port is set, so own toggles capture too
      assign cap_evt[c] = (edge_sel[c] ? (cs2_q[c] & ~cs3_q[c])
                                       : (~cs2_q[c] & cs3_q[c])) // R14 R20 R24
                          & (c == 1 || !pulse_mode); // R19
      always_ff @(posedge core_clk) begin
         if (!rst_n) cap_q[c] <= 8'h00;
         else if (cap_evt[c]) cap_q[c] <= cnt_q; // R12 R18
      end
   end

   // ---------------- output compare ----------------
   assign pen = {ctrl_b_q[`ECCT_B_COMPARE_TWO_PIN_ENABLE], ctrl_b_q[`ECCT_B_COMPARE_ONE_PIN_ENABLE]};
   assign lvl = {ctrl_a_q[`ECCT_A_OLVL2], ctrl_a_q[`ECCT_A_OLVL1]};
   for (c = 0; c < 2; c++) begin : g_cmp
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            out_q[c] <= 1'b0;
            oe_q[c] <= 1'b0;
         end else begin
            oe_q[c] <= pen[c] & ~timd_q;
            if (tick && cnt_q == cmp_lo_q[c] && pen[c]) out_q[c] <= lvl[c]; // R22
         end
      end
   end

   // ---------------- flags ----------------
   assign set_evt[`ECCT_FL_OVF] = tick && !reload_pend_q && cnt_q == `ECCT_CNT_MAX; // R6
   assign set_evt[`ECCT_FL_CAP1] = cap_evt[0]; // R15
   assign set_evt[`ECCT_FL_CAP2] = cap_evt[1]; // R15
   assign set_evt[`ECCT_FL_CMP1] = tick && cnt_q == cmp_lo_q[0]; // R22 R23
   assign set_evt[`ECCT_FL_CMP2] = tick && cnt_q == cmp_lo_q[1]; // R22 R23
   // the alternate counter address is deliberately absent here
   assign clr_acc[`ECCT_FL_OVF] = acc && avs_address == `ECCT_OFS_CNT_LO; // R8 R9
   assign clr_acc[`ECCT_FL_CAP1] = acc && avs_address == `ECCT_OFS_CAP1_LO; // R17
   assign clr_acc[`ECCT_FL_CAP2] = acc && avs_address == `ECCT_OFS_CAP2_LO; // R17
   assign clr_acc[`ECCT_FL_CMP1] = acc && avs_address == `ECCT_OFS_CMP1_LO;
   assign clr_acc[`ECCT_FL_CMP2] = acc && avs_address == `ECCT_OFS_CMP2_LO;

   genvar f;
   for (f = 0; f < 5; f++) begin : g_flag
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            flag_q[f] <= 1'b0;
            arm_q[f] <= 1'b0;
            pend_q[f] <= 1'b0;
         end else begin
            // a new event beats a clear landing on the same tick
            if (set_evt[f]) flag_q[f] <= 1'b1;
            else if (pend_q[f] && tick) flag_q[f] <= 1'b0; // R8 R17 R25
            if (stat_rd && flag_q[f]) arm_q[f] <= 1'b1; // R8 R17
            else if (clr_acc[f]) arm_q[f] <= 1'b0;
            if (clr_acc[f] && arm_q[f]) pend_q[f] <= 1'b1; // R8 R17
            else if (tick) pend_q[f] <= 1'b0;
         end
      end
   end

   // ---------------- interrupt request ----------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= ~cpu_irq_mask & // R7 R15
                  ((flag_q[`ECCT_FL_OVF] & ctrl_a_q[`ECCT_A_OVERFLOW_IRQ_ENABLE]) |
                   ((flag_q[`ECCT_FL_CAP1] | flag_q[`ECCT_FL_CAP2])
                    & ctrl_a_q[`ECCT_A_CAPTURE_IRQ_ENABLE]) | // R16
                   ((flag_q[`ECCT_FL_CMP1] | flag_q[`ECCT_FL_CMP2])
                    & ctrl_a_q[`ECCT_A_COMPARE_IRQ_ENABLE])); // R22
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign compare_one_output = out_q[0];
   assign compare_two_output = out_q[1];
   assign compare_one_output_en = oe_q[0];
   assign compare_two_output_en = oe_q[1];
   assign timer_irq = irq_q;

   // ---------------- checks ----------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   count_reload_a: assert property (tick && reload_pend_q |=> cnt_q == `ECCT_CNT_RELOAD) // R2
      else $error("counter not reloaded with fc");
   count_step_a: assert property (tick && !reload_pend_q |=> cnt_q == $past(cnt_q) + 8'h01) // R1
      else $error("counter did not step by one");
   halt_freeze_a: assert property (halt_mode |=> $stable(cnt_q)) // R11
      else $error("counter moved during halt");
   ovf_set_a: assert property (set_evt[`ECCT_FL_OVF] // R6
                               |=> flag_q[`ECCT_FL_OVF] && cnt_q == 8'h00)
      else $error("wrap did not set overflow");
   irq_masked_a: assert property (cpu_irq_mask |=> !timer_irq) // R7
      else $error("irq raised while cpu mask set");
   irq_ovf_a: assert property (flag_q[`ECCT_FL_OVF] && ctrl_a_q[`ECCT_A_OVERFLOW_IRQ_ENABLE] // R7
                               && !cpu_irq_mask |=> timer_irq)
      else $error("pending overflow not requested");
   capture_copy_a: assert property (cap_evt[1] |=> cap_q[1] == $past(cnt_q) && flag_q[2]) // R12
      else $error("capture two lost count or flag");
   ovf_clear_path_a: assert property ($rose(pend_q[`ECCT_FL_OVF]) // R9
                                      |-> $past(clr_acc[`ECCT_FL_OVF]))
      else $error("overflow clear armed by wrong address");
   pulse_no_cap_a: assert property (pulse_mode |-> !cap_evt[0]) // R19
      else $error("channel one captured in pulse mode");
   cmp_match_a: assert property (set_evt[`ECCT_FL_CMP1] && pen[0] // R22
                                 |=> flag_q[3] && out_q[0] == $past(lvl[0]))
      else $error("compare one match not applied");
   cap_edge_a: assert property (cap_evt[0] // R14
                                |-> cs2_q[0] == edge_sel[0] && cs3_q[0] != cs2_q[0])
      else $error("capture one on wrong edge");

   cov_overflow: cover property (set_evt[`ECCT_FL_OVF]);
   cov_capture_two: cover property (cap_evt[1] && pulse_mode);
   cov_flag_clear: cover property ($fell(flag_q[`ECCT_FL_OVF]));
   cov_irq: cover property ($rose(timer_irq));
endmodule // ecct_timer

// *** sim/ecct_timer_test.sv ***
// self-checking bench for the 8-bit capture/compare timer
module ecct_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ecct_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   ecct_word_t avs_writedata = 32'h0;
   ecct_word_t avs_readdata;
   logic avs_waitrequest;
   // capture pins idle high, the level the synchronisers come out of reset with
   logic cap1 = 1'b1;
   logic cap2 = 1'b1;
   logic osc = 1'b0;
   logic mask = 1'b0;
   logic halt = 1'b1;
   logic cmp1_o, cmp1_en, cmp2_o, cmp2_en, irq;
   int err_count = 0;
   int checks = 0;
   int osc_div = 0;
   int k;
   ecct_byte_t q, c;
   ecct_byte_t ra [11] = '{8'h51, 8'h52, 8'h53, 8'h56, 8'h57, 8'h5e, 8'h5f, 8'h58, 8'h59,
      8'h5b, 8'h40};
   ecct_byte_t re [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hfc,
      8'hfc, 8'h00};
   // core clocks per tick for select 00, 01, 10, 11 (slow: 4 oscillator edges of 6 clocks)
   int dv [4] = '{4, 2, 8, 24};

   always #10 core_clk = ~core_clk;

   // slow oscillator made on the core clock so its phase to the prescaler stays fixed
   always @(posedge core_clk) begin
      osc_div <= (osc_div == 2) ? 0 : osc_div + 1;
      if (osc_div == 2)
         osc <= ~osc;
   end

   ecct_timer #(.SLOW_DIV(4)) i_ecct_timer (
      .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .capture_one_input(cap1), .capture_two_input(cap2),
      .secondary_oscillator_clock(osc), .cpu_irq_mask(mask), .halt_mode(halt),
      .compare_one_output(cmp1_o), .compare_one_output_en(cmp1_en),
      .compare_two_output(cmp2_o), .compare_two_output_en(cmp2_en), .timer_irq(irq));

   task automatic finish_test();
      $display("err_count=%0d checks=%0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk8(input ecct_byte_t got, input ecct_byte_t exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   // one avalon access; request held until waitrequest is sampled low
   // a missing answer is left to the watchdog
   task automatic acc(input logic wr, input ecct_byte_t a, input ecct_byte_t d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input ecct_byte_t a, input ecct_byte_t exp);
      acc(1'b0, a, 8'h00);
      chk8(q, exp);
   endtask

   task automatic st(input int b, input logic exp);
      acc(1'b0, 8'h53, 8'h00);
      chk1(q[b], exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 11; i++)
         rd(ra[i], re[i]);
      acc(1'b1, 8'h57, 8'ha5);
      rd(8'h57, 8'ha5);
      acc(1'b1, 8'h5e, 8'h5a);
      rd(8'h5e, 8'h5a);
      acc(1'b1, 8'h40, 8'h77);
      rd(8'h40, 8'h00);
      acc(1'b1, 8'h57, 8'h00);
      cyc(40);
      rd(8'h59, 8'hfc);
      halt <= 1'b0;
      // exactly sixteen ticks must pass in sixteen tick periods for every clock choice
      for (int s = 0; s < 4; s++) begin
         acc(1'b1, 8'h51, ecct_byte_t'(s << 2));
         cyc(30);
         acc(1'b0, 8'h5b, 8'h00);
         c = q;
         cyc(dv[s] * 16 - 3);
         acc(1'b0, 8'h5b, 8'h00);
         chk8(ecct_byte_t'(q - c), 8'h10);
      end
      acc(1'b1, 8'h51, 8'h08);
      acc(1'b1, 8'h5b, 8'h00);
      cyc(10);
      acc(1'b0, 8'h59, 8'h00);
      chk1(q inside {8'hfc, 8'hfd}, 1'b1);
      acc(1'b1, 8'h51, 8'h04);
      acc(1'b1, 8'h52, 8'h20);
      acc(1'b1, 8'h59, 8'h00);
      for (k = 0; k < 300 && irq !== 1'b1; k++)
         @(posedge core_clk);
      chk1(irq, 1'b1);
      st(5, 1'b1);
      mask <= 1'b1;
      cyc(3);
      chk1(irq, 1'b0);
      mask <= 1'b0;
      cyc(3);
      chk1(irq, 1'b1);
      st(5, 1'b1);
      acc(1'b0, 8'h5b, 8'h00);
      cyc(10);
      st(5, 1'b1);
      acc(1'b0, 8'h59, 8'h00);
      cyc(10);
      st(5, 1'b0);
      chk1(irq, 1'b0);
      // frozen count makes the captured value known
      halt <= 1'b1;
      // channel one falling, channel two rising, pulse mode on
      acc(1'b1, 8'h52, 8'h80);
      acc(1'b1, 8'h51, 8'h12);
      acc(1'b0, 8'h5b, 8'h00);
      c = q;
      cap1 <= 1'b0;
      cyc(8);
      st(7, 1'b0);
      cap2 <= 1'b0;
      cyc(8);
      st(4, 1'b0);
      cap2 <= 1'b1;
      cyc(8);
      st(4, 1'b1);
      rd(8'h5d, c);
      chk1(irq, 1'b1);
      acc(1'b1, 8'h51, 8'h00);
      cap1 <= 1'b1;
      cyc(8);
      st(7, 1'b0);
      cap1 <= 1'b0;
      cyc(8);
      st(7, 1'b1);
      rd(8'h55, c);
      mask <= 1'b1;
      cyc(3);
      chk1(irq, 1'b0);
      mask <= 1'b0;
      st(4, 1'b1);
      acc(1'b0, 8'h5d, 8'h00);
      halt <= 1'b0;
      cyc(20);
      // both channels were armed and then accessed, so both clear at the first tick
      st(4, 1'b0);
      st(7, 1'b0);
      acc(1'b1, 8'h57, 8'h40);
      acc(1'b1, 8'h52, 8'h05);
      acc(1'b1, 8'h51, 8'h84);
      acc(1'b1, 8'h59, 8'h00);
      // reload to FCh, then 68 ticks of two clocks to reach 40h
      for (k = 0; k < 400 && cmp1_o !== 1'b1; k++)
         @(posedge core_clk);
      chk1(k inside {[130:142]}, 1'b1);
      chk1(cmp1_en, 1'b1);
      chk1(cmp2_en, 1'b0);
      // compare two matched at 00h on the way up, but its pin is not enabled
      chk1(cmp2_o, 1'b0);
      st(6, 1'b1);
      halt <= 1'b1;
      cap1 <= 1'b1;
      rst_n <= 1'b0;
      cyc(6);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(8'h59, 8'hfc);
      rd(8'h57, 8'h00);
      chk1(cmp1_o, 1'b0);
      finish_test();
   end
endmodule // ecct_timer_test
